// *** core/mitd_core.v ***
// Purpose: instruction decode and instruction-cycle timing for an 8-bit core
// Assumes: ref_clk_in is the oscillator; program memory word valid at phase 3
// Notes:   execution semantics live downstream; this block decodes and paces
//
// Operation
// - each instruction is one 14-bit word holding opcode and operands
// - opcodes sort into byte, bit, jump and literal-and-control classes
// - instructions finish in one instruction cycle unless an exception applies
// - subroutine_jump and computed_subroutine_jump take two cycles
// - subroutine_exit, exit_with_constant, interrupt_exit take two cycles
// - jumps and taken skips of the skip family take two cycles
// - indirect access with pointer into program memory adds one cycle
// - one instruction cycle is four oscillator clocks
// - file register instructions read, modify, then store to chosen target
// - named file register is read even when the instruction only writes
// - register_operand is a 7-bit direct address 0x00 to 0x7f
// - result_target 0 sends result to accumulator, 1 to file register
// - position_in_register picks one bit of the 8-bit file register
// - pointer_id picks pointer_register and indirect_port pair 0 or 1
// - ignored_position bits never change decoding
// - auto_step_kind picks pre/post increment or decrement of the pointer
`include "mitd_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module mitd_core (
    // clock and reset
    input wire ref_clk_in,
    input wire sys_rst_in,
    // program memory word (prefetched) and execution feedback
    input wire [13:0] instr_in,
    input wire skip_true_in,
    input wire [1:0] ptr_in_prog_in,
    // timing
    output reg [1:0] q_phase_out,
    output reg cycle_end_out,
    output reg instr_done_out,
    output reg flush_out,
    output reg indir_wait_out,
    output reg fetch_out,
    // decoded word
    output reg instr_valid_out,
    output reg [1:0] class_out,
    output reg [3:0] opcode_out,
    output reg [6:0] register_operand_out,
    output reg result_target_out,
    output reg [2:0] position_in_register_out,
    output reg [10:0] immediate_constant_out,
    output reg [3:0] imm_width_out,
    output reg pointer_id_out,
    output reg [1:0] auto_step_kind_out,
    output reg indirect_out,
    output reg flow_change_out,
    output reg is_skip_out,
    // register file strobes
    output reg file_rd_out,
    output reg file_wr_out,
    output reg acc_wr_out
);

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    localparam ST_EXEC = 2'h0;
    localparam ST_INDIR = 2'h1;
    localparam ST_FLUSH = 2'h2;

    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [1:0] q_r;
    reg ind_prog_r;
    // set while a flush belongs to an instruction, clear for the reset flush
    reg flush_tail_r;
    reg uses_file_r;

    // ----------------------------------------
    // combinational decode of the incoming word
    // ----------------------------------------
    reg [1:0] d_cls;
    reg [3:0] d_op;
    reg [10:0] d_k;
    reg [3:0] d_kw;
    reg d_file;
    reg d_dest;
    reg d_ind;
    reg d_pid;
    reg [1:0] d_mm;
    reg d_flow;
    reg d_skip;

    always @*
    begin
        d_cls = instr_in[`MITD_CLS_HI:`MITD_CLS_LO];
        d_op = 4'h0;
        d_k = 11'h000;
        d_kw = 4'h0;
        d_file = 1'b0;
        d_dest = 1'b0;
        d_ind = 1'b0;
        d_pid = 1'b0;
        d_mm = 2'h0;
        d_flow = 1'b0;
        d_skip = 1'b0;
        case (d_cls)
            `MITD_CLS_BYTE:
            begin
                d_op = instr_in[`MITD_BOP_HI:`MITD_BOP_LO];
                d_file = 1'b1;
                d_dest = instr_in[`MITD_D_BIT];
                d_skip = (d_op == `MITD_BOP_DEC_SKIP) || (d_op == `MITD_BOP_INC_SKIP);
            end
            `MITD_CLS_BIT:
            begin
                d_op = {2'h0, instr_in[`MITD_TOP_HI:`MITD_TOP_LO]};
                d_file = 1'b1;
                // bit set/clear writes back; bit tests leave the register alone
                d_dest = ~instr_in[`MITD_TOP_HI];
                d_skip = instr_in[`MITD_TOP_HI];
            end
            `MITD_CLS_JUMP:
            begin
                // subroutine_jump and absolute_jump share the long target form
                d_op = {3'h0, instr_in[`MITD_JSEL_BIT]};
                d_k = instr_in[`MITD_K11_HI:0];
                d_kw = `MITD_KW_LONG;
                d_flow = 1'b1;
            end
            default:
            begin
                d_op = instr_in[`MITD_BOP_HI:`MITD_BOP_LO];
                d_k = {3'h0, instr_in[`MITD_K8_HI:0]};
                d_kw = `MITD_KW_LIT;
                if (d_op == `MITD_LOP_CTRL)
                begin
                    d_kw = `MITD_KW_NONE;
                    d_k = 11'h000;
                    if (instr_in[`MITD_CFIX_BIT])
                    begin
                        // upper literal bits and bit 2 are don't-care here
                        d_flow = 1'b1;
                    end
                    else
                    begin
                        // indirect move through a pointer; bits 7:5 don't-care
                        d_ind = 1'b1;
                        d_pid = instr_in[`MITD_PID_BIT];
                        d_mm = instr_in[`MITD_MM_HI:`MITD_MM_LO];
                    end
                end
                else if ((d_op == `MITD_LOP_REL_JUMP) || (d_op == `MITD_LOP_EXIT_CONST))
                begin
                    d_flow = 1'b1;
                end
            end
        endcase
        if (d_file)
        begin
            // direct file address; the indirect ports alias the two pointers
            d_k = 11'h000;
            if ((instr_in[`MITD_F_HI:`MITD_F_LO] == `MITD_IND_PORT0) ||
                (instr_in[`MITD_F_HI:`MITD_F_LO] == `MITD_IND_PORT1))
            begin
                d_ind = 1'b1;
                d_pid = instr_in[`MITD_F_LO];
            end
        end
    end

    // ----------------------------------------
    // instruction cycle sequencer
    // ----------------------------------------
    wire cyc_end = (q_r == `MITD_Q_LAST);
    wire extra = flow_change_out | (is_skip_out & skip_true_in);
    wire load = cyc_end & (st_nxt == ST_EXEC);

    always @*
    begin
        st_nxt = st_r;
        if (cyc_end)
        begin
            case (st_r)
                ST_EXEC:
                begin
                    if (ind_prog_r)
                        st_nxt = ST_INDIR;
                    else if (extra)
                        st_nxt = ST_FLUSH;
                    else
                        st_nxt = ST_EXEC;
                end
                ST_INDIR:
                begin
                    if (extra)
                        st_nxt = ST_FLUSH;
                    else
                        st_nxt = ST_EXEC;
                end
                default:
                    st_nxt = ST_EXEC;
            endcase
        end
    end

    // the last data cycle is where the file access lands
    wire data_cyc = (st_r == ST_INDIR) || ((st_r == ST_EXEC) && !ind_prog_r);

    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            // start in a flush cycle so the first word is fetched before use
            st_r <= ST_FLUSH;
            q_r <= `MITD_Q_FIRST;
            ind_prog_r <= 1'b0;
            flush_tail_r <= 1'b0;
            uses_file_r <= 1'b0;
            q_phase_out <= `MITD_Q_FIRST;
            cycle_end_out <= 1'b0;
            instr_done_out <= 1'b0;
            flush_out <= 1'b1;
            indir_wait_out <= 1'b0;
            fetch_out <= 1'b0;
            instr_valid_out <= 1'b0;
            class_out <= `MITD_CLS_BYTE;
            opcode_out <= 4'h0;
            register_operand_out <= 7'h00;
            result_target_out <= 1'b0;
            position_in_register_out <= 3'h0;
            immediate_constant_out <= 11'h000;
            imm_width_out <= 4'h0;
            pointer_id_out <= 1'b0;
            auto_step_kind_out <= 2'h0;
            indirect_out <= 1'b0;
            flow_change_out <= 1'b0;
            is_skip_out <= 1'b0;
            file_rd_out <= 1'b0;
            file_wr_out <= 1'b0;
            acc_wr_out <= 1'b0;
        end
        else
        begin
            q_r <= q_r + 2'h1;
            q_phase_out <= q_r + 2'h1;
            st_r <= st_nxt;
            cycle_end_out <= cyc_end;
            // an instruction is done when the sequencer returns to EXEC; a flush
            // only ends an instruction when one entered it, not after reset
            if (cyc_end)
            begin
                flush_tail_r <= (st_nxt == ST_FLUSH) & (st_r != ST_FLUSH);
            end
            instr_done_out <= cyc_end & (st_nxt == ST_EXEC) &
                              ((st_r != ST_FLUSH) | flush_tail_r);
            flush_out <= (st_nxt == ST_FLUSH);
            indir_wait_out <= (st_nxt == ST_INDIR);
            fetch_out <= cyc_end;
            // file access strobes: read always, write to the chosen target, the accumulator for byte ops only
            file_rd_out <= (q_r == `MITD_Q_PRE_RD) & data_cyc & uses_file_r;
            file_wr_out <= (q_r == `MITD_Q_PRE_WR) & data_cyc & uses_file_r &
                           result_target_out;
            acc_wr_out <= (q_r == `MITD_Q_PRE_WR) & data_cyc & uses_file_r &
                          !result_target_out & (class_out == `MITD_CLS_BYTE);
            if (load)
            begin
                instr_valid_out <= 1'b1;
                class_out <= d_cls;
                opcode_out <= d_op;
                register_operand_out <= instr_in[`MITD_F_HI:`MITD_F_LO];
                result_target_out <= d_dest;
                position_in_register_out <= instr_in[`MITD_B_HI:`MITD_B_LO];
                immediate_constant_out <= d_k;
                imm_width_out <= d_kw;
                pointer_id_out <= d_pid;
                auto_step_kind_out <= d_mm;
                indirect_out <= d_ind;
                flow_change_out <= d_flow;
                is_skip_out <= d_skip;
                uses_file_r <= d_file;
                ind_prog_r <= d_ind & ptr_in_prog_in[d_pid];
            end
            else if (cyc_end)
            begin
                // a flushed or stretched slot issues nothing new
                instr_valid_out <= 1'b0;
                ind_prog_r <= 1'b0;
                if (st_nxt == ST_FLUSH)
                begin
                    uses_file_r <= 1'b0;
                    flow_change_out <= 1'b0;
                    is_skip_out <= 1'b0;
                end
            end
        end
    end

endmodule // mitd_core

`default_nettype wire

// *** core/mitd_defs.vh ***
// Purpose: constants for the instruction decode and timing front end
// Assumes: 14-bit instruction words, four oscillator clocks per instruction cycle
// Notes:   opcode encodings below belong to this core
`ifndef MITD_DEFS_VH
`define MITD_DEFS_VH

// ----------------------------------------
// instruction cycle phases
// ----------------------------------------
`define MITD_Q_W 2
`define MITD_Q_FIRST 2'h0
`define MITD_Q_LAST 2'h3
`define MITD_Q_PRE_RD 2'h0
`define MITD_Q_PRE_WR 2'h2

// ----------------------------------------
// word fields
// ----------------------------------------
`define MITD_IW 14
`define MITD_CLS_HI 13
`define MITD_CLS_LO 12
`define MITD_BOP_HI 11
`define MITD_BOP_LO 8
`define MITD_D_BIT 7
`define MITD_F_HI 6
`define MITD_F_LO 0
`define MITD_TOP_HI 11
`define MITD_TOP_LO 10
`define MITD_B_HI 9
`define MITD_B_LO 7
`define MITD_JSEL_BIT 11
`define MITD_K11_HI 10
`define MITD_K8_HI 7
`define MITD_CFIX_BIT 3
`define MITD_CSEL_HI 1
`define MITD_PID_BIT 2
`define MITD_KW_LONG 4'hb
`define MITD_KW_LIT 4'h8
`define MITD_KW_NONE 4'h0
`define MITD_MM_HI 1
`define MITD_MM_LO 0

// ----------------------------------------
// classes and opcodes
// ----------------------------------------
`define MITD_CLS_BYTE 2'h0
`define MITD_CLS_BIT 2'h1
`define MITD_CLS_JUMP 2'h2
`define MITD_CLS_LIT 2'h3
`define MITD_BOP_DEC_SKIP 4'hb
`define MITD_BOP_INC_SKIP 4'hf
`define MITD_TOP_SKIP_ZERO 2'h2
`define MITD_TOP_SKIP_ONE 2'h3
`define MITD_LOP_CTRL 4'h0
`define MITD_LOP_REL_JUMP 4'h1
`define MITD_LOP_EXIT_CONST 4'h4
`define MITD_CTL_SUB_EXIT 2'h0
`define MITD_CTL_INT_EXIT 2'h1
`define MITD_CTL_CALC_SUB 2'h2
`define MITD_CTL_ACC_REL 2'h3
`define MITD_IND_PORT0 7'h00
`define MITD_IND_PORT1 7'h01

`endif

// *** dv/mitd_props.sv ***
// Purpose: timing and strobe properties of mitd_core
// Assumes: one clock, synchronous active-high reset
// Notes:   bound below; sees only mitd_core ports
`timescale 1ns/1ps
`default_nettype none
module mitd_props (
    // clock, reset, inputs
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire skip_true_in,
    // watched outputs
    input wire [1:0] q_phase_out,
    input wire cycle_end_out,
    input wire fetch_out,
    input wire instr_done_out,
    input wire flush_out,
    input wire indir_wait_out,
    input wire instr_valid_out,
    input wire is_skip_out,
    input wire indirect_out,
    input wire file_rd_out,
    input wire file_wr_out,
    input wire acc_wr_out
);
    // ----------------------------------
    // properties
    // ----------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // indirect skips are left out: their data cycle moves behind the extra fetch
    sequence s_skip_end;
        instr_valid_out && is_skip_out && !indirect_out && q_phase_out == 2'h3;
    endsequence
    property p_phase; !$past(sys_rst_in) |-> q_phase_out - $past(q_phase_out) == 2'h1; endproperty
    a_phase: assert property (p_phase) else $error("phase did not step by one");
    property p_fetch; fetch_out |-> cycle_end_out && q_phase_out == 2'h0; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch outside phase 0");
    property p_done; instr_done_out |-> fetch_out && !flush_out && !indir_wait_out; endproperty
    a_done: assert property (p_done) else $error("done outside a cycle start");
    property p_rmw; file_wr_out || acc_wr_out |-> $past(file_rd_out, 2); endproperty
    a_rmw: assert property (p_rmw) else $error("write without prior read");
    property p_flush; $rose(flush_out) |-> flush_out [*4] ##1 !flush_out; endproperty
    a_flush: assert property (p_flush) else $error("flush not one cycle");
    property p_indir; $rose(indir_wait_out) |-> indir_wait_out [*4] ##1 !indir_wait_out; endproperty
    a_indir: assert property (p_indir) else $error("extra cycle not one cycle");
    property p_skip_hit; s_skip_end ##0 skip_true_in |=> flush_out; endproperty
    a_skip_hit: assert property (p_skip_hit) else $error("taken skip not flushed");
    property p_skip_miss; s_skip_end ##0 !skip_true_in |=> instr_done_out && !flush_out; endproperty
    a_skip_miss: assert property (p_skip_miss) else $error("untaken skip slow");
    c_flush: cover property ($rose(flush_out));
    c_indir: cover property ($rose(indir_wait_out));
    c_skip: cover property (s_skip_end ##0 skip_true_in);
endmodule // mitd_props

bind mitd_core mitd_props u_props (.*);
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: directed bench for mitd_core decode and timing
// Assumes: 50 MHz clock; inputs change on rising edges
// Notes:   outputs sampled on falling edges, clear of updates
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ----------------------------------
    // signals
    // ----------------------------------
    // plain literal op: one cycle, no file access, fills gaps between tests
    localparam logic [13:0] fill_word = 14'h3255;
    logic ref_clk_in, sys_rst_in, skip_true_in;
    logic [13:0] instr_in;
    logic [1:0] ptr_in_prog_in;
    wire [1:0] q_phase_out, class_out, auto_step_kind_out;
    wire [2:0] position_in_register_out;
    wire [3:0] imm_width_out;
    wire [6:0] register_operand_out;
    wire [10:0] immediate_constant_out;
    wire instr_done_out, flush_out, fetch_out, instr_valid_out, result_target_out;
    wire pointer_id_out, file_rd_out, file_wr_out, acc_wr_out;
    wire [3:0] opcode_out;
    wire flow_change_out;
    int n_errors = 0;
    int samples_checked = 0;
    int guard;

    mitd_core dut (.*, .cycle_end_out(), .indir_wait_out(), .indirect_out(), .is_skip_out());

    // ----------------------------------
    // helpers
    // ----------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task tick;
        @(negedge ref_clk_in);
        guard++;
        if (guard > 60)
        begin
            n_errors++;
            $display("ERROR %s expected %0d seen %0d", "wait", 60, guard);
            report_and_stop();
        end
    endtask

    // present the word mid-cycle so it cannot race a load edge
    task automatic start(input logic [13:0] w, input logic [1:0] p, input logic s);
        guard = 0;
        do tick(); while (q_phase_out !== 2'h1);
        @(posedge ref_clk_in);
        instr_in <= w;
        ptr_in_prog_in <= p;
        skip_true_in <= s;
        do tick(); while ({fetch_out, instr_valid_out} !== 2'h3);
    endtask

    // sx of all x skips the strobe check
    task automatic finish(input int cyc, input logic [2:0] sx);
        int n;
        logic [2:0] seen;
        n = 0;
        seen = 3'h0;
        @(posedge ref_clk_in);
        instr_in <= fill_word;
        do
        begin
            tick();
            n++;
            seen = seen | {file_rd_out, file_wr_out, acc_wr_out};
        end
        while (instr_done_out !== 1'b1);
        chk("edges", 4 * cyc, n);
        if (sx !== 3'bxxx)
            chk("strobes", sx, seen);
    endtask

    task automatic exec(input logic [13:0] w, input logic [1:0] p, input logic s, input int c,
        input logic [2:0] sx);
        start(w, p, s);
        finish(c, sx);
    endtask

    task do_reset;
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b1;
        instr_in <= fill_word;
        repeat (3) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk("flush", 16'h1, flush_out);
        chk("valid", 16'h0, instr_valid_out);
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
    endtask

    // ----------------------------------
    // scenarios
    // ----------------------------------
    task t_byte;
        exec(14'h07a0, 2'h0, 1'b0, 1, 3'b110);
        start(14'h077f, 2'h0, 1'b0);
        chk("class", 16'h0, class_out);
        chk("file", 16'h7f, register_operand_out);
        chk("target", 16'h0, result_target_out);
        chk("opcode", 16'h7, opcode_out);
        chk("flow", 16'h0, flow_change_out);
        chk("width", 16'h0, imm_width_out);
        finish(1, 3'b101);
        $display("t_byte done");
    endtask

    task t_bit;
        for (int i = 0; i < 4; i++)
        begin
            start(i[1] ? 14'h1e90 : 14'h1a90, 2'h0, i[0]);
            chk("bit", 16'h5, position_in_register_out);
            finish(1 + i[0], 3'b100);
        end
        $display("t_bit done");
    endtask

    task t_skip;
        for (int i = 0; i < 4; i++)
            exec(i[1] ? 14'h0fb0 : 14'h0bb0, 2'h0, i[0], 1 + i[0], 3'b110);
        $display("t_skip done");
    endtask

    task t_flow;
        logic [13:0] fw [8] = '{14'h25a5, 14'h31c3, 14'h3477, 14'h3008,
            14'h3009, 14'h300a, 14'h300b, 14'h30fc};
        start(14'h2da5, 2'h0, 1'b0);
        chk("class", 16'h2, class_out);
        chk("const", 16'h5a5, immediate_constant_out);
        chk("width", 16'hb, imm_width_out);
        chk("opcode", 16'h1, opcode_out);
        chk("flow", 16'h1, flow_change_out);
        finish(2, 3'h0);
        foreach (fw[i])
            exec(fw[i], 2'h0, 1'b0, 2, 3'h0);
        $display("t_flow done");
    endtask

    task t_indirect;
        for (int m = 0; m < 4; m++)
        begin
            start(14'h30e4 | 14'(m), m[0] ? 2'h2 : 2'h1, 1'b0);
            chk("pointer", 16'h1, pointer_id_out);
            chk("step", 16'(m), auto_step_kind_out);
            finish(1 + m[0], 3'bxxx);
        end
        exec(14'h0781, 2'h2, 1'b0, 2, 3'b110);
        exec(14'h0780, 2'h2, 1'b0, 1, 3'b110);
        exec(14'h0b81, 2'h2, 1'b1, 3, 3'b110);
        $display("t_indirect done");
    endtask

    task t_reset;
        start(14'h2da5, 2'h0, 1'b0);
        do_reset();
        exec(14'h07a0, 2'h0, 1'b0, 1, 3'b110);
        $display("t_reset done");
    endtask

    initial
    begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    initial
    begin
        sys_rst_in = 1'b1;
        skip_true_in = 1'b0;
        ptr_in_prog_in = 2'h0;
        instr_in = fill_word;
        do_reset();
        t_byte();
        t_bit();
        t_skip();
        t_flow();
        t_indirect();
        t_reset();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
